// File: rtl/fxcd_pkg.sv
// constants, types and register map of the flash extended command host
// assumes a 20 MHz mclk and a flash part strobed by plain chip/write/output enables
package fxcd_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_NS    = 50;
  localparam int SETUP_NS  = 50;
  localparam int WE_LOW_NS = 100;
  localparam int OE_LOW_NS = 150;
  localparam int HOLD_NS   = 50;
  localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WE_CYC    = 4'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] OE_CYC    = 4'((OE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC  = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CNT_LAST  = 4'h1;

  // ==========================================================================
  // command codes and fixed data
  localparam logic [7:0] OPC_XSTAT   = 8'h71;
  localparam logic [7:0] OPC_SWAP    = 8'h72;
  localparam logic [7:0] OPC_PBLD    = 8'h74;
  localparam logic [7:0] OPC_PBRD    = 8'h75;
  localparam logic [7:0] OPC_SEQ     = 8'hE0;
  localparam logic [7:0] OPC_PBFL    = 8'h0C;
  localparam logic [7:0] OPC_TWOB    = 8'hFB;
  localparam logic [7:0] OPC_LOCK    = 8'h77;
  localparam logic [7:0] OPC_UPST    = 8'h97;
  localparam logic [7:0] OPC_UPINFO  = 8'h99;
  localparam logic [7:0] OPC_ERALL   = 8'hA7;
  localparam logic [7:0] OPC_RBCFG   = 8'h96;
  localparam logic [7:0] OPC_SLEEP   = 8'hF0;
  localparam logic [7:0] OPC_ABORT   = 8'h80;
  localparam logic [7:0] OPC_CONFIRM = 8'hD0;
  localparam logic [7:0] DATA_HI_ZERO = 8'h00;
  localparam logic [7:0] RB_MODE_MIN  = 8'h01;
  localparam logic [7:0] RB_MODE_MAX  = 8'h04;
  localparam logic [20:0] ADDR_ZERO   = 21'h0;
  localparam logic [20:0] ADDR_INC_X8  = 21'h1;
  localparam logic [20:0] ADDR_INC_X16 = 21'h2;

  // ==========================================================================
  // sequencing
  localparam logic [2:0] STEPS_ONE   = 3'h1;
  localparam logic [2:0] STEPS_TWO   = 3'h2;
  localparam logic [2:0] STEPS_THREE = 3'h3;
  localparam logic [2:0] STEP_FIRST  = 3'h0;
  localparam logic [2:0] STEP_SECOND = 3'h1;
  localparam logic [2:0] STEP_THIRD  = 3'h2;
  localparam logic [2:0] STEP_FEED   = 3'h3;

  // ==========================================================================
  // register map (byte offsets) and bit positions
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_COUNT  = 8'h0C;
  localparam logic [7:0] REG_CFG    = 8'h10;
  localparam logic [7:0] REG_FEED   = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_RDATA  = 8'h1C;
  localparam logic [7:0] REG_IRQ_ST = 8'h20;
  localparam logic [7:0] REG_IRQ_MK = 8'h24;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_READY   = 2;
  localparam int IRQ_BAD     = 3;
  localparam int CTRL_GO_BIT = 8;

  typedef enum logic [3:0] {
    OP_XSTAT = 4'h0, OP_SWAP = 4'h1, OP_PBRD = 4'h2, OP_PBLD = 4'h3,
    OP_SEQ = 4'h4, OP_PBFL = 4'h5, OP_TWOB = 4'h6, OP_LOCK = 4'h7,
    OP_UPST = 4'h8, OP_UPINFO = 4'h9, OP_ERALL = 4'hA, OP_RBCFG = 4'hB,
    OP_SLEEP = 4'hC, OP_ABORT = 4'hD
  } fxcd_op_type;

  typedef struct packed {
    logic        is_read;
    logic [20:0] addr;
    logic [15:0] data;
  } fxcd_cyc_req_type;

  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [20:0] addr;
    logic [15:0] dq_o;
    logic        dq_oe;
  } fxcd_pins_type;

endpackage

// File: rtl/fxcd_bus_cycle.sv
// one flash bus cycle: setup, write or output strobe, hold
// assumes start is only raised while the engine is idle
`timescale 1ns/1ps
module fxcd_bus_cycle import fxcd_pkg::*; (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             start,
  input  wire fxcd_cyc_req_type req,
  input  wire logic [15:0]      dq_i,
  output logic                  done,
  output logic [15:0]           rdata,
  output fxcd_pins_type         pins
);

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001, PH_SETUP = 4'b0010, PH_STROBE = 4'b0100, PH_HOLD = 4'b1000
  } fxcd_phase_type;

  typedef struct packed {
    fxcd_phase_type   ph;
    logic [3:0]       cnt;
    fxcd_cyc_req_type req;
    logic [15:0]      rdata;
    logic             done;
  } fxcd_cyc_state_type;

  fxcd_cyc_state_type s_r, s_nxt;

  // ==========================================================================
  // sequencing
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.ph)
      PH_IDLE: begin
        if (start) begin
          s_nxt.req = req;
          s_nxt.ph  = PH_SETUP;
          s_nxt.cnt = SETUP_CYC;
        end
      end
      PH_SETUP: begin
        s_nxt.cnt = s_r.cnt - CNT_LAST;
        if (s_r.cnt == CNT_LAST) begin
          s_nxt.ph  = PH_STROBE;
          s_nxt.cnt = s_r.req.is_read ? OE_CYC : WE_CYC;
        end
      end
      PH_STROBE: begin
        s_nxt.cnt = s_r.cnt - CNT_LAST;
        if (s_r.cnt == CNT_LAST) begin
          // sample at the end of the output strobe, after access time
          if (s_r.req.is_read) begin
            s_nxt.rdata = dq_i;
          end
          s_nxt.ph  = PH_HOLD;
          s_nxt.cnt = HOLD_CYC;
        end
      end
      PH_HOLD: begin
        s_nxt.cnt = s_r.cnt - CNT_LAST;
        if (s_r.cnt == CNT_LAST) begin
          s_nxt.ph   = PH_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '{ph: PH_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // pins
  always_comb begin
    pins.ce_n  = (s_r.ph == PH_IDLE);
    pins.we_n  = !((s_r.ph == PH_STROBE) && !s_r.req.is_read);
    pins.oe_n  = !((s_r.ph == PH_STROBE) && s_r.req.is_read);
    pins.addr  = s_r.req.addr;
    pins.dq_o  = s_r.req.data;
    pins.dq_oe = (s_r.ph != PH_IDLE) && !s_r.req.is_read;
  end

  assign done  = s_r.done;
  assign rdata = s_r.rdata;

endmodule // fxcd_bus_cycle

// File: rtl/fxcd_host_ctrl.sv
// host controller for the extended command set of a parallel flash
// assumes classic wishbone on the software side and synchronous flash pins
`timescale 1ns/1ps

module fxcd_host_ctrl import fxcd_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  output logic [20:0]      flash_addr,
  input  wire logic [15:0] dq_i,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  output logic             chip_select_0_n,
  output logic             chip_select_1_n,
  output logic             write_enable_n,
  output logic             output_enable_n,
  output logic             byte_select_n,
  input  wire logic        ready_busy_output
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_ISSUE = 4'b0010, ST_WAIT = 4'b0100, ST_FEED = 4'b1000
  } fxcd_fsm_type;

  typedef struct packed {
    fxcd_fsm_type st;
    fxcd_op_type  op;
    logic [2:0]   step;
    logic [20:0]  addr;
    logic [15:0]  wdata;
    logic [7:0]   cnt;
    logic [7:0]   left;
    logic [20:0]  feed_addr;
    logic [15:0]  feed_data;
    logic         byte_mode;
    logic [15:0]  rdata;
    logic [3:0]   irq_st;
    logic [3:0]   irq_mk;
    logic         ack;
    logic [31:0]  rd;
    logic         uploaded;
    logic         sleeping;
    logic         rb_q;
  } fxcd_ctl_state_type;

  fxcd_ctl_state_type s_r, s_nxt;
  fxcd_cyc_req_type   req;
  fxcd_pins_type      pins;
  logic               cyc_start;
  logic               cyc_done;
  logic [15:0]        cyc_rdata;
  logic               take;
  logic               go;
  logic               feed_go;
  logic [3:0]         set;
  logic [3:0]         clr;
  logic [31:0]        msk;
  logic [31:0]        wv;
  logic               bad;
  logic [9:0]         seg_end;

  // ==========================================================================
  // helpers
  function automatic logic [7:0] opc(input fxcd_op_type o);
    case (o)
      OP_XSTAT:  opc = OPC_XSTAT;
      OP_SWAP:   opc = OPC_SWAP;
      OP_PBRD:   opc = OPC_PBRD;
      OP_PBLD:   opc = OPC_PBLD;
      OP_SEQ:    opc = OPC_SEQ;
      OP_PBFL:   opc = OPC_PBFL;
      OP_TWOB:   opc = OPC_TWOB;
      OP_LOCK:   opc = OPC_LOCK;
      OP_UPST:   opc = OPC_UPST;
      OP_UPINFO: opc = OPC_UPINFO;
      OP_ERALL:  opc = OPC_ERALL;
      OP_RBCFG:  opc = OPC_RBCFG;
      OP_SLEEP:  opc = OPC_SLEEP;
      default:   opc = OPC_ABORT;
    endcase
  endfunction

  function automatic logic [2:0] steps_of(input fxcd_op_type o);
    case (o)
      OP_SWAP, OP_SLEEP, OP_ABORT: steps_of = STEPS_ONE;
      OP_SEQ, OP_PBFL, OP_TWOB:    steps_of = STEPS_THREE;
      default:                     steps_of = STEPS_TWO;
    endcase
  endfunction

  function automatic fxcd_cyc_req_type step_req(input fxcd_ctl_state_type s);
    fxcd_cyc_req_type r;
    logic [7:0]       lo;
    logic [7:0]       hi;
    logic             sw;
    r.is_read = 1'b0;
    r.addr    = s.addr;
    // upper data byte zero on count cycles
    r.data    = {DATA_HI_ZERO, s.cnt};
    lo        = (s.op == OP_TWOB) ? s.wdata[7:0] : s.cnt;
    hi        = (s.op == OP_TWOB) ? s.wdata[15:8] : DATA_HI_ZERO;
    // in byte mode the first byte follows the lowest address bit
    sw        = s.byte_mode && s.addr[0];
    case (s.step)
      STEP_FIRST: begin
        r.addr = ADDR_ZERO;
        r.data = {DATA_HI_ZERO, opc(s.op)};
      end
      STEP_SECOND: begin
        case (s.op)
          // report read at the given address
          OP_XSTAT, OP_PBRD: r.is_read = 1'b1;
          OP_PBLD: r.data = s.wdata;
          OP_SEQ: r.data = {DATA_HI_ZERO, s.cnt};
          OP_PBFL, OP_TWOB: r.data = {DATA_HI_ZERO, sw ? hi : lo};
          OP_LOCK: r.data = {DATA_HI_ZERO, OPC_CONFIRM};
          OP_RBCFG: begin
            r.addr = ADDR_ZERO;
            r.data = {DATA_HI_ZERO, s.wdata[7:0]};
          end
          default: begin
            r.addr = ADDR_ZERO;
            r.data = {DATA_HI_ZERO, OPC_CONFIRM};
          end
        endcase
      end
      STEP_THIRD: begin
        // program target address on the last cycle
        if (s.op == OP_SEQ) begin
          r.data = {DATA_HI_ZERO, DATA_HI_ZERO};
        end else begin
          r.data = {DATA_HI_ZERO, sw ? lo : hi};
        end
      end
      default: begin
        r.addr = s.feed_addr;
        r.data = s.feed_data;
      end
    endcase
    return r;
  endfunction

  // ==========================================================================
  // checks made before an order is accepted
  always_comb begin
    // last byte touched must stay in the same segment
    seg_end = {2'b00, s_r.addr[7:0]} + (s_r.byte_mode ? {2'b00, s_r.cnt} : {1'b0, s_r.cnt, 1'b1});
    bad = 1'b0;
    if (wb_dat_i[3:0] > OP_ABORT) begin
      bad = 1'b1;
    end
    if ((wb_dat_i[3:0] == OP_TWOB) && !s_r.byte_mode) begin
      bad = 1'b1;
    end
    if (((wb_dat_i[3:0] == OP_SEQ) || (wb_dat_i[3:0] == OP_PBFL)) && (|seg_end[9:8])) begin
      bad = 1'b1;
    end
    // out-of-range mode byte refused as improper
    if ((wb_dat_i[3:0] == OP_RBCFG) && ((s_r.wdata[7:0] < RB_MODE_MIN) || (s_r.wdata[7:0] > RB_MODE_MAX))) begin
      bad = 1'b1;
    end
  end

  // ==========================================================================
  // register slave and sequencer
  always_comb begin
    s_nxt   = s_r;
    set     = '0;
    clr     = '0;
    go      = 1'b0;
    feed_go = 1'b0;
    msk     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wv      = wb_dat_i & msk;
    take    = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.ack = take;
    if (take) begin
      case (wb_adr_i)
        REG_ADDR:   s_nxt.rd = {11'h000, s_r.addr};
        REG_WDATA:  s_nxt.rd = {16'h0000, s_r.wdata};
        REG_COUNT:  s_nxt.rd = {24'h000000, s_r.cnt};
        REG_CFG:    s_nxt.rd = {31'h00000000, s_r.byte_mode};
        // lock state valid only once uploaded
        REG_STATUS: s_nxt.rd = {27'h0000000, s_r.sleeping, s_r.uploaded, s_r.rb_q,
                                (s_r.st == ST_FEED), (s_r.st != ST_IDLE)};
        REG_RDATA:  s_nxt.rd = {16'h0000, s_r.rdata};
        REG_IRQ_ST: s_nxt.rd = {28'h0000000, s_r.irq_st};
        REG_IRQ_MK: s_nxt.rd = {28'h0000000, s_r.irq_mk};
        default:    s_nxt.rd = 32'h00000000;
      endcase
      if (wb_we_i) begin
        case (wb_adr_i)
          REG_CTRL:   go = wb_sel_i[1] && wb_dat_i[CTRL_GO_BIT];
          REG_ADDR:   s_nxt.addr = 21'((({11'h000, s_r.addr}) & ~msk) | wv);
          REG_WDATA:  s_nxt.wdata = 16'((({16'h0000, s_r.wdata}) & ~msk) | wv);
          REG_COUNT:  if (wb_sel_i[0]) s_nxt.cnt = wb_dat_i[7:0];
          REG_CFG:    if (wb_sel_i[0]) s_nxt.byte_mode = wb_dat_i[0];
          REG_FEED:   begin
            feed_go = 1'b1;
            s_nxt.feed_data = wb_dat_i[15:0];
          end
          REG_IRQ_ST: clr = wv[3:0];
          REG_IRQ_MK: if (wb_sel_i[0]) s_nxt.irq_mk = wb_dat_i[3:0];
          default: ;
        endcase
      end
    end

    case (s_r.st)
      ST_IDLE: begin
        if (feed_go) begin
          set[IRQ_REFUSED] = 1'b1;
        end
        if (go && bad) begin
          set[IRQ_BAD] = 1'b1;
        end else if (go) begin
          s_nxt.op       = fxcd_op_type'(wb_dat_i[3:0]);
          s_nxt.step     = STEP_FIRST;
          s_nxt.sleeping = 1'b0;
          s_nxt.st       = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        set[IRQ_REFUSED] = go || feed_go;
        s_nxt.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (go || feed_go) begin
          set[IRQ_REFUSED] = 1'b1;
        end
        if (cyc_done) begin
          if (s_r.step == STEP_SECOND && (s_r.op == OP_XSTAT || s_r.op == OP_PBRD)) begin
            s_nxt.rdata = cyc_rdata;
          end
          s_nxt.step = s_r.step + STEPS_ONE;
          s_nxt.st   = ST_ISSUE;
          if (s_r.step == STEP_FEED) begin
            s_nxt.feed_addr = s_r.feed_addr + (s_r.byte_mode ? ADDR_INC_X8 : ADDR_INC_X16);
            s_nxt.left      = s_r.left - 8'h01;
            s_nxt.step      = STEP_FEED;
            s_nxt.st        = ST_FEED;
            if (s_r.left == 8'h00) begin
              s_nxt.st = ST_IDLE;
              set[IRQ_DONE] = 1'b1;
            end
          end else if (s_r.step + STEPS_ONE == steps_of(s_r.op)) begin
            if (s_r.op == OP_SEQ) begin
              // items follow from the fourth cycle
              // count register holds items minus one
              s_nxt.left      = s_r.cnt;
              s_nxt.feed_addr = s_r.addr;
              s_nxt.step      = STEP_FEED;
              s_nxt.st        = ST_FEED;
            end else begin
              s_nxt.st = ST_IDLE;
              set[IRQ_DONE] = 1'b1;
              if (s_r.op == OP_UPST) begin
                s_nxt.uploaded = 1'b1;
              end
              if (s_r.op == OP_SLEEP) begin
                s_nxt.sleeping = 1'b1;
              end
            end
          end
        end
      end
      ST_FEED: begin
        if (go) begin
          set[IRQ_REFUSED] = 1'b1;
        end
        // the sequence waits for software, so a slow feeder only stretches the load
        if (feed_go) begin
          s_nxt.st = ST_ISSUE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    // ready edge reported on every rising edge of the ready/busy input, whatever the sequencer state
    s_nxt.rb_q = ready_busy_output;
    if (ready_busy_output && !s_r.rb_q) begin
      set[IRQ_READY] = 1'b1;
    end
    // a new event beats a clear in the same cycle
    s_nxt.irq_st = (s_r.irq_st & ~clr) | set;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '{st: ST_IDLE, op: OP_XSTAT, rb_q: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // flash cycles
  assign cyc_start = (s_r.st == ST_ISSUE);
  assign req       = step_req(s_r);

  fxcd_bus_cycle u_cycle (
    .mclk  (mclk),
    .rst_b (rst_b),
    .start (cyc_start),
    .req   (req),
    .dq_i  (dq_i),
    .done  (cyc_done),
    .rdata (cyc_rdata),
    .pins  (pins)
  );

  // chip selects high between cycles and while asleep
  assign chip_select_0_n = pins.ce_n;
  assign chip_select_1_n = pins.ce_n;
  assign write_enable_n  = pins.we_n;
  assign output_enable_n = pins.oe_n;
  assign flash_addr      = pins.addr;
  assign dq_o            = pins.dq_o;
  assign dq_oe           = pins.dq_oe;
  // byte-wide select low in byte mode
  assign byte_select_n   = !s_r.byte_mode;
  assign wb_ack_o        = s_r.ack;
  assign wb_dat_o        = s_r.rd;
  assign irq             = |(s_r.irq_st & s_r.irq_mk);

endmodule // fxcd_host_ctrl

// File: sim/fxcd_host_props.sv
// pin checker for the flash extended command host
// assumes one clock domain; bound to every host instance
`timescale 1ns/1ps
module fxcd_host_props (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] dq_o,
  input wire logic        dq_oe,
  input wire logic        chip_select_0_n,
  input wire logic        chip_select_1_n,
  input wire logic        write_enable_n,
  input wire logic        output_enable_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // strobe shapes
  sequence s_wr_pulse;
    !write_enable_n [*2] ##1 write_enable_n;
  endsequence
  sequence s_rd_pulse;
    !output_enable_n [*3] ##1 output_enable_n;
  endsequence
  // ==========================================================================
  // pin relations
  a_cs_pair: assert property (chip_select_0_n == chip_select_1_n)
    else $error("chip selects differ");
  a_write_width: assert property ($fell(write_enable_n) |-> s_wr_pulse)
    else $error("write strobe width wrong");
  a_read_width: assert property ($fell(output_enable_n) |-> s_rd_pulse)
    else $error("read strobe width wrong");
  a_read_no_drive: assert property (!output_enable_n |-> !dq_oe)
    else $error("data driven during read");
  a_strobe_setup: assert property ((!write_enable_n || !output_enable_n) |->
    !chip_select_0_n && !$past(chip_select_0_n)) else $error("strobe without select setup");
  a_write_steady: assert property (!write_enable_n |->
    dq_oe && $stable(dq_o) && $stable(flash_addr)) else $error("write data moved under strobe");
  a_strobe_hold: assert property (($rose(write_enable_n) || $rose(output_enable_n)) |->
    !chip_select_0_n ##1 chip_select_0_n) else $error("hold cycle wrong");
  a_cs_gap: assert property ($rose(chip_select_0_n) |=> chip_select_0_n)
    else $error("cycles too close");
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
endmodule // fxcd_host_props

bind fxcd_host_ctrl fxcd_host_props i_props (.mclk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .flash_addr,
  .dq_o, .dq_oe, .chip_select_0_n, .chip_select_1_n, .write_enable_n, .output_enable_n);

// File: sim/fxcd_flash_model.sv
// behavioural flash part at its pins: logs write cycles, answers reads
// assumes synchronous strobes from the host on mclk
`timescale 1ns/1ps
module fxcd_flash_model (
  input  wire logic        mclk,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [20:0] addr,
  input  wire logic [15:0] dq_o,
  output logic [15:0]      dq_i,
  output logic             ready_busy_output
);
  logic [36:0] log_q[$];
  logic [7:0]  last_cmd = 8'h00;
  logic [15:0] dq_last  = 16'h0000;
  logic        we_q     = 1'h1;
  logic        pb_sel   = 1'h0;
  logic        upl      = 1'h0;
  int          busy_cnt = 0;
  logic [15:0] rd;
  // ==========================================================================
  // read side
  // report or buffer data, locked until upload
  assign rd = {upl ? addr[7:0] : 8'hFF, 8'h5A ^ {7'h00, pb_sel}};
  // a released bus shows the inverse of the last value, never a held copy
  assign dq_i = oe_n ? ~dq_last : rd;
  // level mode: low while the sequencer runs
  assign ready_busy_output = (busy_cnt == 0);
  // ==========================================================================
  // write decode
  always @(posedge mclk) begin
    we_q <= we_n;
    if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
    if (!oe_n) dq_last <= rd;
    if (!we_q && we_n && !ce_n) begin
      log_q.push_back({addr, dq_o});
      // only the low byte is decoded
      last_cmd <= dq_o[7:0];
      if (dq_o[7:0] == 8'h72) pb_sel <= !pb_sel;
      if (dq_o[7:0] == 8'hD0 && last_cmd == 8'hA7) busy_cnt <= 40;
      if (dq_o[7:0] == 8'hD0 && last_cmd == 8'h97) upl <= 1'h1;
    end
  end
endmodule // fxcd_flash_model

// File: sim/fxcd_host_ctrl_tb_top.sv
// self-checking bench for the flash extended command host
// assumes the flash model file and the bound pin checker
`timescale 1ns/1ps
module fxcd_host_ctrl_tb_top import fxcd_pkg::*;;
  logic        mclk = 1'h0, rst_b = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [7:0]  adr  = 8'h00;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] dat  = 32'h0, wdo, rq;
  logic        ack, irq, cs0, cs1, wen, oen, bsn, dqoe, rb;
  logic [20:0] fa;
  logic [15:0] dqo, dqi;
  logic [15:0] fv[4];
  logic [3:0]  bo[3] = '{4'h6, 4'h4, 4'hB};
  logic [38:0] ex_q[$];
  int          fail_count = 0, check_count = 0, cyc_n = 0;

  always #25 mclk = ~mclk;
  fxcd_host_ctrl i_dut (.mclk, .rst_b, .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wdo), .wb_ack_o(ack), .irq, .flash_addr(fa), .dq_i(dqi),
    .dq_o(dqo), .dq_oe(dqoe), .chip_select_0_n(cs0), .chip_select_1_n(cs1), .write_enable_n(wen),
    .output_enable_n(oen), .byte_select_n(bsn), .ready_busy_output(rb));
  fxcd_flash_model i_flash (.mclk, .ce_n(cs0 | cs1), .we_n(wen), .oe_n(oen), .addr(fa), .dq_o(dqo),
    .dq_i(dqi), .ready_busy_output(rb));

  // ==========================================================================
  // helpers
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // the whole run needs under a thousand cycles; this only cuts a hang
  always @(posedge mclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
    adr <= a;
    dat <= d;
    we  <= w;
    sel <= 4'hF;
    cyc <= 1'h1;
    stb <= 1'h1;
    do begin
      @(posedge mclk);
    end while (ack !== 1'h1);
    rq = wdo;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      wb(REG_STATUS, 32'h0, 1'h0);
      n++;
    end while (rq[b] !== v && n < 100);
  endtask
  // mode bit 1: low byte only, bit 0: address compared too
  task automatic ex(input logic [1:0] m, input logic [20:0] a, input logic [15:0] d);
    ex_q.push_back({m, a, d});
  endtask
  task automatic run(input logic [3:0] op, input int nf);
    logic [38:0] e;
    logic [36:0] g;
    logic [15:0] m;
    wb(REG_CTRL, {23'h0, 1'h1, 4'h0, op}, 1'h1);
    for (int i = 0; i < nf; i++) begin
      poll(1, 1'h1);
      wb(REG_FEED, {16'h0, fv[i]}, 1'h1);
    end
    poll(0, 1'h0);
    chk("cycles", 32'(ex_q.size()), 32'(i_flash.log_q.size()));
    while (ex_q.size() > 0 && i_flash.log_q.size() > 0) begin
      e = ex_q.pop_front();
      g = i_flash.log_q.pop_front();
      m = e[38] ? 16'h00FF : 16'hFFFF;
      chk("data", {16'h0, e[15:0] & m}, {16'h0, g[15:0] & m});
      if (e[37]) chk("addr", {11'h0, e[36:16]}, {11'h0, g[36:16]});
    end
    ex_q.delete();
    i_flash.log_q.delete();
  endtask

  // ==========================================================================
  // scenarios
  initial begin
    logic [20:0] a;
    logic [15:0] d;
    logic [7:0]  c;
    void'($urandom(32'h37837415));
    repeat (16) @(posedge mclk);
    chk("idle pins", 32'h7C, 32'({cs0, cs1, wen, oen, bsn, irq, dqoe}));
    rst_b <= 1'h1;
    @(posedge mclk);
    wb(8'h40, 32'h0, 1'h0);
    chk("unmapped", 32'h0, rq);
    wb(REG_IRQ_MK, 32'hF, 1'h1);
    a = 21'($urandom());
    wb(REG_ADDR, {11'h0, a}, 1'h1);
    ex(2'h0, 21'h0, {8'h00, OPC_PBRD});
    run(4'h2, 0);
    chk("irq done", 32'h1, 32'(irq));
    wb(REG_IRQ_MK, 32'h0, 1'h1);
    chk("irq masked", 32'h0, 32'(irq));
    wb(REG_IRQ_ST, 32'hF, 1'h1);
    wb(REG_IRQ_MK, 32'hF, 1'h1);
    chk("irq cleared", 32'h0, 32'(irq));
    wb(REG_RDATA, 32'h0, 1'h0);
    chk("locked read", 32'hFF5A, rq);
    ex(2'h0, 21'h0, {8'h00, OPC_SWAP});
    run(4'h1, 0);
    ex(2'h0, 21'h0, {8'h00, OPC_UPST});
    ex(2'h0, 21'h0, {8'h00, OPC_CONFIRM});
    run(4'h8, 0);
    wb(REG_STATUS, 32'h0, 1'h0);
    chk("uploaded", 32'h1, 32'(rq[3]));
    ex(2'h0, 21'h0, {8'h00, OPC_XSTAT});
    run(4'h0, 0);
    wb(REG_RDATA, 32'h0, 1'h0);
    chk("report", {16'h0, a[7:0], 8'h5B}, rq);
    for (int k = 1; k < 5; k++) begin
      wb(REG_WDATA, 32'(k), 1'h1);
      ex(2'h0, 21'h0, {8'h00, OPC_RBCFG});
      ex(2'h0, 21'h0, 16'(k));
      run(4'hB, 0);
    end
    ex(2'h0, 21'h0, {8'h00, OPC_LOCK});
    ex(2'h1, a, {8'h00, OPC_CONFIRM});
    run(4'h7, 0);
    d = 16'($urandom());
    wb(REG_WDATA, {16'h0, d}, 1'h1);
    ex(2'h0, 21'h0, {8'h00, OPC_PBLD});
    ex(2'h1, a, d);
    run(4'h3, 0);
    ex(2'h0, 21'h0, {8'h00, OPC_UPINFO});
    ex(2'h0, 21'h0, {8'h00, OPC_CONFIRM});
    run(4'h9, 0);
    ex(2'h0, 21'h0, {8'h00, OPC_ABORT});
    run(4'hD, 0);
    c = 8'($urandom_range(3));
    a = {13'($urandom()), 8'h00};
    wb(REG_ADDR, {11'h0, a}, 1'h1);
    wb(REG_COUNT, {24'h0, c}, 1'h1);
    ex(2'h0, 21'h0, {8'h00, OPC_SEQ});
    ex(2'h0, 21'h0, {8'h00, c});
    ex(2'h0, 21'h0, 16'h0);
    for (int i = 0; i <= c; i++) begin
      fv[i] = {8'($urandom()), 4'h3, 4'($urandom())};
      ex(2'h1, a + 21'(2 * i), fv[i]);
    end
    run(4'h4, c + 1);
    ex(2'h0, 21'h0, {8'h00, OPC_PBFL});
    ex(2'h0, 21'h0, {8'h00, c});
    ex(2'h1, a, 16'h0);
    run(4'h5, 0);
    ex(2'h0, 21'h0, {8'h00, OPC_ERALL});
    ex(2'h0, 21'h0, {8'h00, OPC_CONFIRM});
    run(4'hA, 0);
    wb(REG_STATUS, 32'h0, 1'h0);
    chk("busy pin", 32'h0, 32'(rq[2]));
    poll(2, 1'h1);
    wb(REG_IRQ_ST, 32'h0, 1'h0);
    chk("ready event", 32'h1, 32'(rq[2]));
    ex(2'h0, 21'h0, {8'h00, OPC_SLEEP});
    wb(REG_CTRL, 32'h10C, 1'h1);
    run(4'hD, 0);
    chk("deselect", 32'h3, 32'({cs0, cs1}));
    wb(REG_FEED, 32'h0, 1'h1);
    wb(REG_IRQ_ST, 32'h0, 1'h0);
    chk("refused", 32'h1, 32'(rq[1]));
    wb(REG_ADDR, 32'hF0, 1'h1);
    wb(REG_COUNT, 32'h10, 1'h1);
    wb(REG_WDATA, 32'h5, 1'h1);
    for (int k = 0; k < 3; k++) begin
      wb(REG_IRQ_ST, 32'hF, 1'h1);
      run(bo[k], 0);
      wb(REG_IRQ_ST, 32'h0, 1'h0);
      chk("bad order", 32'h1, 32'(rq[3]));
    end
    wb(REG_CFG, 32'h1, 1'h1);
    wb(REG_COUNT, {24'h0, c}, 1'h1);
    chk("byte mode", 32'h0, 32'(bsn));
    for (int k = 0; k < 2; k++) begin
      d = 16'($urandom());
      wb(REG_ADDR, {11'h0, a[20:1], 1'(k)}, 1'h1);
      wb(REG_WDATA, {16'h0, d}, 1'h1);
      ex(2'h2, 21'h0, {8'h00, OPC_TWOB});
      ex(2'h2, 21'h0, (k != 0) ? {8'h00, d[15:8]} : d);
      ex(2'h2, 21'h0, (k != 0) ? d : {8'h00, d[15:8]});
      run(4'h6, 0);
      ex(2'h2, 21'h0, {8'h00, OPC_PBFL});
      ex(2'h2, 21'h0, (k != 0) ? 16'h0 : {8'h00, c});
      ex(2'h2, 21'h0, (k != 0) ? {8'h00, c} : 16'h0);
      run(4'h5, 0);
    end
    complete_run();
  end
endmodule // fxcd_host_ctrl_tb_top
